// ==== inc/iowdt_pkg.sv ====
// package of constants for the i/o port watchdog
// Summary of operation
// - A host write of a nonzero code to i/o port 443 hex loads the timeout and starts the countdown.
// - Each count of the written code is one second, so 01 is 1 s and 3E is 62 s.
// - Every further write of a nonzero code reloads the written interval and restarts the countdown; a write of 00 stops it.
// - A read of the port stops and disables the watchdog until the next write.
// - On expiry without a refresh the block resets the cpu or raises an interrupt.
package iowdt_pkg;
  localparam logic [15:0] WDT_PORT_ADDR = 16'h0443;
  localparam logic [7:0] CODE_MIN = 8'h01;
  localparam logic [7:0] CODE_MAX = 8'h3E;
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam int CLK_HZ = 125000000;
  localparam int SEC_CYCLES = CLK_HZ;
  localparam int PULSE_NS = 1000;
  localparam int PULSE_CYCLES = (PULSE_NS * 125 + 999) / 1000;
  localparam bit ACT_RESET = 1'b0;
endpackage : iowdt_pkg

// ==== rtl/iowdt_tick.sv ====
// one-second time base for the watchdog
`timescale 1ns/1ps
`default_nettype none
module iowdt_tick #(
  parameter int PERIOD = 125000000
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic restart,
  output logic tick
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  always_comb begin
    next_cnt = cnt + 32'h00000001;
    if (restart || cnt == 32'(PERIOD - 1)) begin
      next_cnt = 32'h00000000;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt <= 32'h00000000;
    end else begin
      cnt <= next_cnt;
    end
  end
  assign tick = !restart && cnt == 32'(PERIOD - 1);
endmodule : iowdt_tick
`default_nettype wire

// ==== rtl/iowdt_top.sv ====
// i/o port watchdog: port decode, countdown and expiry action
`timescale 1ns/1ps
`default_nettype none
module iowdt_top
  import iowdt_pkg::*;
#(
  parameter int SEC_PERIOD = SEC_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [15:0] ioAddr,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [7:0] ioWdata,
  input wire logic actionIrq,
  output logic [7:0] ioRdata,
  output logic ioRdataValid,
  output logic cpuReset,
  output logic irqReq,
  output logic wdtEnabled
);
  // ****************************************
  // port decode
  // ****************************************
  logic hit;
  logic wrHit;
  logic rdHit;
  logic tick;
  assign hit = ioAddr == WDT_PORT_ADDR;
  assign wrHit = hit && ioWrite;
  assign rdHit = hit && ioRead && !ioWrite;

  iowdt_tick #(.PERIOD(SEC_PERIOD)) iowdt_tick_i (
    .clk_sys(clk_sys),
    .rst(rst),
    .restart(wrHit),
    .tick(tick)
  );

  // ****************************************
  // countdown
  // ****************************************
  logic enabled;
  logic next_enabled;
  logic [7:0] remain;
  logic [7:0] next_remain;
  logic [7:0] code;
  logic [7:0] next_code;
  logic expire;
  logic [7:0] pulseCnt;
  logic [7:0] next_pulseCnt;
  logic irq;
  logic next_irq;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic rvalid;

  always_comb begin
    next_enabled = enabled;
    next_remain = remain;
    next_code = code;
    expire = 1'b0;
    if (wrHit) begin
      // a code of zero would not expire but wrap to FF on the next tick; treat it as disable
      next_code = ioWdata;
      next_remain = ioWdata;
      next_enabled = ioWdata != CODE_RESET;
    end else if (rdHit) begin
      next_enabled = 1'b0;
    end else if (enabled && tick) begin
      if (remain == 8'h01) begin
        expire = 1'b1;
        next_enabled = 1'b0;
        next_remain = 8'h00;
      end else begin
        next_remain = remain - 8'h01;
      end
    end
  end

  // ****************************************
  // expiry action and read data
  // ****************************************
  always_comb begin
    next_pulseCnt = pulseCnt;
    next_irq = irq;
    if (expire && actionIrq == ACT_RESET) begin
      next_pulseCnt = 8'(PULSE_CYCLES);
    end else if (pulseCnt != 8'h00) begin
      next_pulseCnt = pulseCnt - 8'h01;
    end
    // irq stays up until host services the port; expiry wins
    if (expire && actionIrq != ACT_RESET) begin
      next_irq = 1'b1;
    end else if (hit && (ioWrite || ioRead)) begin
      next_irq = 1'b0;
    end
    next_rdata = rdHit ? remain : 8'h00;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      enabled <= 1'b0;
      remain <= CODE_RESET;
      code <= CODE_RESET;
      pulseCnt <= 8'h00;
      irq <= 1'b0;
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      enabled <= next_enabled;
      remain <= next_remain;
      code <= next_code;
      pulseCnt <= next_pulseCnt;
      irq <= next_irq;
      rdata <= next_rdata;
      rvalid <= rdHit;
    end
  end

  assign ioRdata = rdata;
  assign ioRdataValid = rvalid;
  assign cpuReset = pulseCnt != 8'h00;
  assign irqReq = irq;
  assign wdtEnabled = enabled;

  // ****************************************
  // checks
  // ****************************************
  property p_write_arms;
    @(posedge clk_sys) disable iff (rst)
      (wrHit && ioWdata != 8'h00) |=> (enabled && remain == $past(ioWdata));
  endproperty
  a_write_arms: assert property (p_write_arms) else $error("write did not arm");

  property p_read_disarms;
    @(posedge clk_sys) disable iff (rst)
      rdHit |=> !enabled;
  endproperty
  a_read_disarms: assert property (p_read_disarms) else $error("read did not disarm");

  property p_disabled_quiet;
    @(posedge clk_sys) disable iff (rst)
      !enabled |-> !expire;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("expiry while off");

  property p_tick_step;
    @(posedge clk_sys) disable iff (rst)
      (enabled && tick && !hit && remain > 8'h01) |=> remain == $past(remain) - 8'h01;
  endproperty
  a_tick_step: assert property (p_tick_step) else $error("count not one per second");

  property p_reload;
    @(posedge clk_sys) disable iff (rst)
      (enabled && wrHit) |=> remain == $past(ioWdata);
  endproperty
  a_reload: assert property (p_reload) else $error("rewrite did not reload");

  property p_reset_pulse;
    @(posedge clk_sys) disable iff (rst)
      (expire && actionIrq == ACT_RESET) |=> cpuReset;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("no cpu reset");

  property p_irq_raise;
    @(posedge clk_sys) disable iff (rst)
      (expire && actionIrq != ACT_RESET) |=> irqReq && !cpuReset;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("no interrupt");

  property p_post_reset;
    @(posedge clk_sys) $fell(rst) |-> !enabled && !cpuReset && !irqReq;
  endproperty
  a_post_reset: assert property (p_post_reset) else $error("not off after reset");

  property p_read_data;
    @(posedge clk_sys) disable iff (rst)
      rdHit |=> ioRdataValid && ioRdata == $past(remain);
  endproperty
  a_read_data: assert property (p_read_data) else $error("bad read data");

  property p_rvalid_pulse;
    @(posedge clk_sys) disable iff (rst)
      !rdHit |=> !ioRdataValid;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("stray valid");

  property p_irq_clear;
    @(posedge clk_sys) disable iff (rst)
      (hit && (ioWrite || ioRead)) |=> !irqReq;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared");

  property p_pulse_end;
    @(posedge clk_sys) disable iff (rst)
      (pulseCnt == 8'h01 && !expire) |=> !cpuReset;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("pulse too long");

  property p_zero_disables;
    @(posedge clk_sys) disable iff (rst)
      (wrHit && ioWdata == CODE_RESET) |=> !enabled;
  endproperty
  a_zero_disables: assert property (p_zero_disables) else $error("zero armed");

  property p_off_hold;
    @(posedge clk_sys) disable iff (rst)
      (!enabled && !wrHit) |=> !enabled;
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("armed without write");
endmodule : iowdt_top
`default_nettype wire

// ==== test/iowdt_host.sv ====
// host processor model issuing i/o port cycles
`timescale 1ns/1ps
`default_nettype none
module iowdt_host (
  input wire logic clk_sys,
  output logic [15:0] ioAddr,
  output logic ioWrite,
  output logic ioRead,
  output logic [7:0] ioWdata
);
  initial begin
    ioAddr = 16'h0000;
    ioWrite = 1'b0;
    ioRead = 1'b0;
    ioWdata = 8'h00;
  end
  // ******************
  // one-cycle port cycle
  // ******************
  // callers keep write codes in 01..3E
  task automatic acc(input logic [15:0] a, input logic w,
                     input logic [7:0] d);
    @(negedge clk_sys);
    ioAddr = a;
    ioWdata = d;
    ioWrite = w;
    ioRead = !w;
    @(negedge clk_sys);
    ioWrite = 1'b0;
    ioRead = 1'b0;
    // released bus shows no stale value
    ioAddr = ~a;
    ioWdata = ~d;
  endtask : acc
endmodule : iowdt_host
`default_nettype wire

// ==== test/iowdt_top_tb.sv ====
// self-checking bench of the i/o port watchdog
`timescale 1ns/1ps
`default_nettype none
module iowdt_top_tb;
  import iowdt_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic actionIrq = 1'b0;
  logic [15:0] ioAddr;
  logic ioWrite, ioRead, ioRdataValid, cpuReset, irqReq, wdtEnabled;
  logic [7:0] ioWdata, ioRdata;
  int errors = 0;
  int tests_run = 0;
  iowdt_host iowdt_host_i (.clk_sys(clk_sys), .ioAddr(ioAddr),
    .ioWrite(ioWrite), .ioRead(ioRead), .ioWdata(ioWdata));
  iowdt_top #(.SEC_PERIOD(10)) iowdt_top_i (.clk_sys(clk_sys), .rst(rst),
    .ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead),
    .ioWdata(ioWdata), .actionIrq(actionIrq), .ioRdata(ioRdata),
    .ioRdataValid(ioRdataValid), .cpuReset(cpuReset), .irqReq(irqReq),
    .wdtEnabled(wdtEnabled));
  initial forever #4 clk_sys = ~clk_sys;
  // ******************
  // shared tasks
  // ******************
  task automatic chk(input string n, input logic [15:0] s, e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic end_sim;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  // edges from the write until the expiry output shows
  task automatic expiry_after(input logic [7:0] c, input int e);
    int n;
    n = 0;
    iowdt_host_i.acc(WDT_PORT_ADDR, 1'b1, c);
    chk("enabled", wdtEnabled, 1'b1);
    while (!(cpuReset === 1'b1 || irqReq === 1'b1)) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (n > 900) begin
        errors++;
        end_sim();
      end
    end
    chk("expiry edges", 16'(n), 16'(e));
  endtask : expiry_after
  task automatic t_refresh;
    iowdt_host_i.acc(WDT_PORT_ADDR, 1'b1, 8'h01);
    repeat (7) @(negedge clk_sys);
    iowdt_host_i.acc(WDT_PORT_ADDR, 1'b1, 8'h01);
    repeat (7) @(negedge clk_sys);
    chk("reload", {cpuReset, wdtEnabled}, 2'b01);
    iowdt_host_i.acc(WDT_PORT_ADDR, 1'b0, 8'h00);
    chk("read", {ioRdataValid, wdtEnabled}, 2'b10);
    repeat (40) @(negedge clk_sys);
    chk("no action", {cpuReset, irqReq}, 2'b00);
  endtask : t_refresh
  // ******************
  // main sequence
  // ******************
  initial begin
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    chk("after reset", {cpuReset, irqReq, wdtEnabled}, 3'b000);
    iowdt_host_i.acc(16'h0442, 1'b1, 8'h02);
    chk("other address", wdtEnabled, 1'b0);
    expiry_after(8'h02, 20);
    chk("reset mode", irqReq, 1'b0);
    repeat (130) @(negedge clk_sys);
    chk("pulse over", cpuReset, 1'b0);
    t_refresh();
    actionIrq = 1'b1;
    expiry_after(8'h03, 30);
    chk("irq mode", {cpuReset, irqReq}, 2'b01);
    iowdt_host_i.acc(WDT_PORT_ADDR, 1'b0, 8'h00);
    chk("irq cleared", irqReq, 1'b0);
    end_sim();
  end
endmodule : iowdt_top_tb
`default_nettype wire
